// file: wscs_sequencer.sv
// wake, shutdown and clock sequencer logic
`timescale 1ns/1ns
`default_nettype none
`include "wscs_map.svh"

module wscs_sequencer #(
   parameter logic [15:0] RESET_TICKS     = 16'(`WSCS_TICKS_RESET),
   parameter logic [15:0] CLK_START_TICKS = 16'(`WSCS_TICKS_CLK_START),
   parameter logic [15:0] IRQ_TICKS       = 16'(`WSCS_TICKS_IRQ),
   parameter logic [15:0] PWR_OFF_TICKS   = 16'(`WSCS_TICKS_PWR_OFF),
   parameter logic [15:0] CLK_STOP_TICKS  = 16'(`WSCS_TICKS_CLK_STOP),
   parameter logic [15:0] WAKE_CYC        = 16'(`WSCS_CYC_WAKE),
   parameter logic [15:0] PWR_ON_CYC      = 16'(`WSCS_CYC_PWR_ON),
   parameter logic [15:0] HF_HALF         = 16'(`WSCS_HF_HALF)
) (
   // clock and reset
   input  wire logic clock,
   input  wire logic rst_b,
   // crystal and supply monitors
   input  wire logic xtal_clk,
   input  wire logic supply_above_18,
   input  wire logic supply_above_27,
   input  wire logic monitor_threshold_select,
   input  wire logic lv_monitor_ok,
   // host controls
   input  wire logic pll_enable,
   input  wire logic shutdown_cmd,
   input  wire logic irq_ack,
   input  wire logic wake_input_a_n,
   input  wire logic wake_input_b_n,
   // outputs
   output logic      reset_out_n,
   output logic      converter_power_off_n,
   output logic      hf_clock_out,
   output logic      irq_n,
   output logic      standby_mode
);

   // saturating counter step
   function automatic logic [15:0] wscs_step(input logic [15:0] v, input logic [15:0] lim);
      wscs_step = (v >= lim) ? lim : 16'(v + 16'h0001);
   endfunction : wscs_step

   wscs_pkg::wscs_pins_t pin_s1;       // first stage, read only by pin_s2
   wscs_pkg::wscs_pins_t pin_s2;       // synchronised pins
   logic                 xtal_q;       // previous crystal level
   logic                 converter_power_off_n_q;       // previous shutdown level
   logic                 ack_q;        // previous acknowledge level
   logic                 tick;         // one cycle per crystal rise
   logic                 converter_power_off_n_edge;    // shutdown command asserted
   logic                 ack_edge;     // host acknowledge
   logic [15:0]          rst_cnt;      // reset timeout ticks
   logic [15:0]          wake_cnt [2]; // low-time filters
   logic [1:0]           wake_evt;     // filtered wake pulses
   wscs_pkg::wscs_pwr_t  pwr_state;    // converter sequence state
   logic [15:0]          pwr_cnt;      // power up / down counter
   logic [15:0]          stop_cnt;     // clock stop ticks
   logic                 stop_run;     // clock stop timer armed
   logic                 clk_stopped;  // clock held off after shutdown
   logic [15:0]          start_cnt;    // clock start ticks
   logic                 hf_run;       // clock output enabled
   logic [15:0]          div_cnt;      // half-period counter
   logic [15:0]          irq_cnt;      // interrupt delay ticks
   logic                 irq_fired;    // one interrupt per clock start
   logic                 supply_ok;    // supply above selected threshold
   logic                 clk_gate;     // all clock enables present
   logic                 any_wake;     // either wake event

   // two-flop synchroniser for all pins
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pin_s1 <= `WSCS_PIN_RESET;
         pin_s2 <= `WSCS_PIN_RESET;
      end else begin
         pin_s1 <= {xtal_clk, supply_above_18, supply_above_27, monitor_threshold_select,
                    lv_monitor_ok, pll_enable, shutdown_cmd, irq_ack,
                    wake_input_a_n, wake_input_b_n};
         pin_s2 <= pin_s1;
      end
   end

   // edge history of synchronised levels
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         xtal_q <= 1'b0;
         converter_power_off_n_q <= 1'b0;
         ack_q  <= 1'b0;
      end else begin
         xtal_q <= pin_s2.xtal;
         converter_power_off_n_q <= pin_s2.converter_power_off_n_cmd;
         ack_q  <= pin_s2.ack;
      end
   end

   // reset, clock start, clock stop, interrupt and power-off delays advance on crystal edges so they track the real oscillator
   assign tick      = pin_s2.xtal & ~xtal_q;
   assign converter_power_off_n_edge = pin_s2.converter_power_off_n_cmd & ~converter_power_off_n_q;
   assign ack_edge  = pin_s2.ack & ~ack_q;
   assign supply_ok = pin_s2.vm_sel ? pin_s2.sup_18 : pin_s2.sup_27;
   assign any_wake  = |wake_evt;

   // reset timeout restarts whenever supply dips below threshold
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rst_cnt     <= 16'h0000;
         reset_out_n <= 1'b0;
      end else if (!supply_ok) begin
         rst_cnt     <= 16'h0000;
         reset_out_n <= 1'b0;
      end else begin
         if (tick) begin
            rst_cnt <= wscs_step(rst_cnt, RESET_TICKS);
         end
         reset_out_n <= (rst_cnt >= RESET_TICKS);
      end
   end

   // wake filters: a glitch shorter than the minimum width is ignored
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         wake_cnt[0] <= 16'h0000;
         wake_cnt[1] <= 16'h0000;
         wake_evt    <= 2'b00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (i == 0 ? pin_s2.wake_a_n : pin_s2.wake_b_n) begin
               wake_cnt[i] <= 16'h0000;
               wake_evt[i] <= 1'b0;
            end else begin
               // one pulse per low assertion, counter then holds
               wake_cnt[i] <= wscs_step(wake_cnt[i], WAKE_CYC);
               wake_evt[i] <= (wake_cnt[i] == 16'(WAKE_CYC - 16'h0001));
            end
         end
      end
   end

   // converter power sequence
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pwr_state <= wscs_pkg::WSCS_PWR_OFF;
         pwr_cnt   <= 16'h0000;
      end else begin
         unique case (pwr_state)
            wscs_pkg::WSCS_PWR_OFF: begin
               pwr_cnt <= 16'h0000;
               if (any_wake) begin
                  pwr_state <= wscs_pkg::WSCS_PWR_UP;
               end
            end
            wscs_pkg::WSCS_PWR_UP: begin
               // short power-on delay in system cycles
               pwr_cnt <= wscs_step(pwr_cnt, PWR_ON_CYC);
               if (pwr_cnt >= 16'(PWR_ON_CYC - 16'h0001)) begin
                  pwr_state <= wscs_pkg::WSCS_PWR_ON;
               end
            end
            wscs_pkg::WSCS_PWR_ON: begin
               pwr_cnt <= 16'h0000;
               if (converter_power_off_n_edge) begin
                  pwr_state <= wscs_pkg::WSCS_PWR_DOWN;
               end
            end
            wscs_pkg::WSCS_PWR_DOWN: begin
               // a new wake aborts the pending power off
               if (any_wake) begin
                  pwr_state <= wscs_pkg::WSCS_PWR_ON;
               end else if (pwr_cnt >= PWR_OFF_TICKS) begin
                  pwr_state <= wscs_pkg::WSCS_PWR_OFF;
               end else if (tick) begin
                  pwr_cnt <= wscs_step(pwr_cnt, PWR_OFF_TICKS);
               end
            end
         endcase
      end
   end

   // power output: pll enable overrides any shutdown
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         converter_power_off_n <= 1'b0;
      end else begin
         converter_power_off_n <= (pwr_state == wscs_pkg::WSCS_PWR_ON) ||
                                  (pwr_state == wscs_pkg::WSCS_PWR_DOWN) ||
                                  pin_s2.pll_en;
      end
   end

   // sleep/standby mode, entered by the first wake input only
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         standby_mode <= 1'b0;
      end else if (wake_evt[0]) begin
         standby_mode <= 1'b1;
      end else if (pwr_state == wscs_pkg::WSCS_PWR_DOWN && pwr_cnt >= PWR_OFF_TICKS) begin
         standby_mode <= 1'b0;
      end
   end

   // clock stop timer: host keeps its clock while it cleans up
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         stop_cnt    <= 16'h0000;
         stop_run    <= 1'b0;
         clk_stopped <= 1'b0;
      end else if (any_wake) begin
         stop_cnt    <= 16'h0000;
         stop_run    <= 1'b0;
         clk_stopped <= 1'b0;
      end else if (converter_power_off_n_edge) begin
         stop_cnt <= 16'h0000;
         stop_run <= 1'b1;
      end else if (stop_run) begin
         if (stop_cnt >= CLK_STOP_TICKS) begin
            stop_run    <= 1'b0;
            clk_stopped <= 1'b1;
         end else if (tick) begin
            stop_cnt <= wscs_step(stop_cnt, CLK_STOP_TICKS);
         end
      end
   end

   assign clk_gate = reset_out_n & pin_s2.lv_ok & pin_s2.pll_en & ~clk_stopped;

   // clock start delay, timed from the last enable to arrive
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         start_cnt <= 16'h0000;
         hf_run    <= 1'b0;
      end else if (!clk_gate) begin
         start_cnt <= 16'h0000;
         hf_run    <= 1'b0;
      end else begin
         if (tick) begin
            start_cnt <= wscs_step(start_cnt, CLK_START_TICKS);
         end
         hf_run <= (start_cnt >= CLK_START_TICKS);
      end
   end

   // clock divider; held low while off so each start begins low
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         div_cnt      <= 16'h0000;
         hf_clock_out <= 1'b0;
      end else if (!hf_run) begin
         div_cnt      <= 16'h0000;
         hf_clock_out <= 1'b0;
      end else if (div_cnt >= 16'(HF_HALF - 16'h0001)) begin
         div_cnt      <= 16'h0000;
         hf_clock_out <= ~hf_clock_out;
      end else begin
         div_cnt <= 16'(div_cnt + 16'h0001);
      end
   end

   // interrupt: set once per clock start, set wins over acknowledge
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         irq_cnt   <= 16'h0000;
         irq_fired <= 1'b0;
         irq_n     <= 1'b1;
      end else begin
         if (!hf_run) begin
            irq_cnt   <= 16'h0000;
            irq_fired <= 1'b0;
         end else if (tick) begin
            irq_cnt <= wscs_step(irq_cnt, IRQ_TICKS);
         end
         if (hf_run && !irq_fired && irq_cnt >= IRQ_TICKS) begin
            irq_fired <= 1'b1;
            irq_n     <= 1'b0;
         end else if (ack_edge) begin
            irq_n <= 1'b1;
         end
      end
   end

endmodule : wscs_sequencer
`default_nettype wire

// file: wscs_map.svh
// constants for the wake, shutdown and clock sequencer
`ifndef WSCS_MAP_SVH
`define WSCS_MAP_SVH

// clock rates
`define WSCS_CLK_PERIOD_NS    10
`define WSCS_XTAL_HZ          32768

// printed times in their own units
`define WSCS_T_RESET_US       1540000
`define WSCS_T_WAKE_NS        1000
`define WSCS_T_PWR_ON_NS      1000
`define WSCS_T_CLK_START_US   31250
`define WSCS_T_IRQ_US         7820
`define WSCS_T_PWR_OFF_US     2930

// derived crystal tick counts (longest-style, rounded down)
// split division keeps the product inside 32-bit integer range
`define WSCS_TICKS_RESET      (((`WSCS_T_RESET_US / 1000) * `WSCS_XTAL_HZ) / 1000)
`define WSCS_TICKS_CLK_START  ((`WSCS_T_CLK_START_US * `WSCS_XTAL_HZ) / 1000000)
`define WSCS_TICKS_IRQ        ((`WSCS_T_IRQ_US * `WSCS_XTAL_HZ) / 1000000)
`define WSCS_TICKS_PWR_OFF    ((`WSCS_T_PWR_OFF_US * `WSCS_XTAL_HZ) / 1000000)
`define WSCS_TICKS_CLK_STOP   64

// derived system cycle counts (least times, rounded up)
`define WSCS_CYC_WAKE  ((`WSCS_T_WAKE_NS + `WSCS_CLK_PERIOD_NS - 1) / `WSCS_CLK_PERIOD_NS)
`define WSCS_CYC_PWR_ON ((`WSCS_T_PWR_ON_NS + `WSCS_CLK_PERIOD_NS - 1) / `WSCS_CLK_PERIOD_NS)
`define WSCS_HF_HALF          20

// synchroniser reset value: wake inputs idle high
`define WSCS_PIN_RESET        10'h003

`endif

// file: wscs_pkg.sv
// types for the wake, shutdown and clock sequencer
package wscs_pkg;

   // pins sampled through the synchroniser
   typedef struct packed {
      logic xtal;          // crystal clock level
      logic sup_18;        // supply above lower threshold
      logic sup_27;        // supply above upper threshold
      logic vm_sel;        // monitor threshold select
      logic lv_ok;         // low-voltage monitor satisfied
      logic pll_en;        // pll enabled
      logic converter_power_off_n_cmd;      // shutdown command level
      logic ack;           // interrupt acknowledge level
      logic wake_a_n;      // first wake input
      logic wake_b_n;      // second wake input
   } wscs_pins_t;

   // converter power sequence
   typedef enum logic [1:0] {
      WSCS_PWR_OFF  = 2'b00,
      WSCS_PWR_UP   = 2'b01,
      WSCS_PWR_ON   = 2'b10,
      WSCS_PWR_DOWN = 2'b11
   } wscs_pwr_t;

endpackage : wscs_pkg

// file: wscs_host_model.sv
// host model that answers the sequencer interrupt
`timescale 1ns/1ns
`default_nettype none
module wscs_host_model (
   // clock
   input  wire logic clock,
   // interrupt handshake
   input  wire logic irq_n,
   input  wire logic slow,
   output var logic  irq_ack
);
   // ack held until irq seen high again, so the edge is never lost
   initial begin
      irq_ack = 1'b0;
      forever begin
         @(negedge clock);
         if (irq_n === 1'b0) begin
            repeat (slow ? 40 : 2) @(negedge clock);
            irq_ack = 1'b1;
            while (irq_n !== 1'b1) @(negedge clock);
            irq_ack = 1'b0;
         end
      end
   end
endmodule : wscs_host_model
`default_nettype wire

// file: wscs_sequencer_chk.sv
// checker for the wake, shutdown and clock sequencer ports
`timescale 1ns/1ns
`default_nettype none
module wscs_sequencer_chk #(
   parameter logic [15:0] RESET_TICKS = 16'h0004,
   parameter logic [15:0] WAKE_CYC    = 16'h000A,
   parameter logic [15:0] HF_HALF     = 16'h0004
) (
   // clock and reset
   input  wire logic clock,
   input  wire logic rst_b,
   // inputs watched
   input  wire logic xtal_clk,
   input  wire logic supply_above_18,
   input  wire logic supply_above_27,
   input  wire logic monitor_threshold_select,
   input  wire logic pll_enable,
   input  wire logic irq_ack,
   input  wire logic wake_input_a_n,
   // outputs watched
   input  wire logic reset_out_n,
   input  wire logic converter_power_off_n,
   input  wire logic hf_clock_out,
   input  wire logic irq_n,
   input  wire logic standby_mode
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   logic [15:0] lo_cnt;   // low run of the clock output
   logic [15:0] tick_cnt; // crystal ticks with supply good
   logic [15:0] a_run;    // low run of first wake pin
   logic        xq;       // crystal level one cycle ago
   logic        a_ok;     // a long enough wake seen
   wire         sup_ok = monitor_threshold_select ? supply_above_18 : supply_above_27;
   // raw pins lead the synchronised copies, so counts here are never short
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         lo_cnt <= 16'h0000;
         tick_cnt <= 16'h0000;
         a_run <= 16'h0000;
         xq <= 1'b0;
         a_ok <= 1'b0;
      end else begin
         xq <= xtal_clk;
         lo_cnt <= hf_clock_out ? 16'h0000 : lo_cnt + 16'h0001;
         tick_cnt <= !sup_ok ? 16'h0000 : tick_cnt + 16'((xtal_clk & !xq));
         a_run <= wake_input_a_n ? 16'h0000 : a_run + 16'h0001;
         a_ok <= a_ok | (a_run >= WAKE_CYC - 16'h0001);
      end
   end
   sequence s_pll_held;
      pll_enable [*4];
   endsequence
   sequence s_ack_idle;
      (!irq_ack) [*5];
   endsequence
   chk_reset_timeout: assert property ($rose(reset_out_n) |-> tick_cnt >= RESET_TICKS)
      else $error("reset output released early");
   chk_reset_drop: assert property ((!sup_ok) [*5] |-> !reset_out_n)
      else $error("reset output high with supply low");
   chk_clock_gate: assert property ((!reset_out_n) [*4] |-> !hf_clock_out)
      else $error("clock output runs in reset");
   chk_first_low: assert property ($rose(hf_clock_out) |-> lo_cnt >= HF_HALF)
      else $error("clock output low phase short");
   chk_irq_cause: assert property ($fell(irq_n) |-> reset_out_n)
      else $error("interrupt without released reset");
   chk_irq_hold: assert property (s_ack_idle ##0 !irq_n |=> !irq_n)
      else $error("interrupt dropped without ack");
   chk_irq_release: assert property ($rose(irq_n) |-> $past(irq_ack, 2))
      else $error("interrupt cleared without ack");
   chk_pwr_pll: assert property (s_pll_held ##0 converter_power_off_n |=> converter_power_off_n)
      else $error("power output fell with pll on");
   chk_standby_wake: assert property ($rose(standby_mode) |-> a_ok)
      else $error("standby without long wake");
endmodule : wscs_sequencer_chk
bind wscs_sequencer wscs_sequencer_chk #(.RESET_TICKS(RESET_TICKS), .WAKE_CYC(WAKE_CYC),
   .HF_HALF(HF_HALF)) wscs_sequencer_chk_inst (.clock(clock), .rst_b(rst_b),
   .xtal_clk(xtal_clk), .supply_above_18(supply_above_18), .supply_above_27(supply_above_27),
   .monitor_threshold_select(monitor_threshold_select), .pll_enable(pll_enable),
   .irq_ack(irq_ack), .wake_input_a_n(wake_input_a_n), .reset_out_n(reset_out_n),
   .converter_power_off_n(converter_power_off_n), .hf_clock_out(hf_clock_out),
   .irq_n(irq_n), .standby_mode(standby_mode));
`default_nettype wire

// file: tb_wscs_sequencer.sv
// self-checking bench for the wake, shutdown and clock sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_wscs_sequencer;
   logic clock, rst_b, xtal_clk, supply_above_18, supply_above_27, monitor_threshold_select;
   logic lv_monitor_ok, pll_enable, shutdown_cmd, irq_ack, wake_input_a_n, wake_input_b_n;
   logic reset_out_n, converter_power_off_n, hf_clock_out, irq_n, standby_mode, slow, act;
   int bad_count, samples_checked, seed, xc;
   logic [2:0] q[$]; // expected {reset, power, irq} in order
   logic [2:0] prev; // last output vector seen
   // small counts keep the run short
   wscs_sequencer #(.RESET_TICKS(16'h0004), .CLK_START_TICKS(16'h0008), .IRQ_TICKS(16'h0004),
      .PWR_OFF_TICKS(16'h0006), .CLK_STOP_TICKS(16'h0003), .WAKE_CYC(16'h000A),
      .PWR_ON_CYC(16'h000A), .HF_HALF(16'h0004)) wscs_sequencer_inst (.clock(clock),
      .rst_b(rst_b), .xtal_clk(xtal_clk), .supply_above_18(supply_above_18),
      .supply_above_27(supply_above_27), .monitor_threshold_select(monitor_threshold_select),
      .lv_monitor_ok(lv_monitor_ok), .pll_enable(pll_enable), .shutdown_cmd(shutdown_cmd),
      .irq_ack(irq_ack), .wake_input_a_n(wake_input_a_n), .wake_input_b_n(wake_input_b_n),
      .reset_out_n(reset_out_n), .converter_power_off_n(converter_power_off_n),
      .hf_clock_out(hf_clock_out), .irq_n(irq_n), .standby_mode(standby_mode));
   wscs_host_model wscs_host_model_inst (.clock(clock), .irq_n(irq_n), .slow(slow),
      .irq_ack(irq_ack));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // crystal stand-in: one tick every 20 cycles
   always @(negedge clock) begin
      xc <= (xc == 9) ? 0 : xc + 1;
      if (xc == 9) xtal_clk <= ~xtal_clk;
   end
   task automatic chk(input logic [2:0] got, input logic [2:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // each output change takes the oldest note; a change with none noted fails
   always @(negedge clock) begin
      if (rst_b && {reset_out_n, converter_power_off_n, irq_n} !== prev) begin
         prev = {reset_out_n, converter_power_off_n, irq_n};
         chk(prev, q.size() ? q.pop_front() : ~prev);
      end
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask : cyc
   // bounded wait for all notes to be used up
   task automatic drain(input int lim);
      for (int i = 0; i < lim && q.size() != 0; i++) @(negedge clock);
      chk(3'(q.size()), 3'h0);
      q.delete();
   endtask : drain
   // watch the clock output for any high level
   task automatic hf_act(input int n);
      act = 1'b0;
      repeat (n) begin
         @(negedge clock);
         act = act | hf_clock_out;
      end
   endtask : hf_act
   task automatic end_of_test();
      $display("counts mismatches=%0d compares=%0d", bad_count, samples_checked);
      if (bad_count == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   initial begin
      seed = 59;
      rst_b = 1'b0;
      // random levels while reset holds every flop; defined levels come before release
      {supply_above_18, supply_above_27, lv_monitor_ok, pll_enable} = 4'($random(seed));
      {shutdown_cmd, wake_input_a_n, wake_input_b_n} = 3'($random(seed));
      {xtal_clk, slow, xc, bad_count, samples_checked} = '0;
      monitor_threshold_select = 1'($random(seed));
      prev = 3'h1;
      fork
         begin
            cyc(20000);
            bad_count++;
            end_of_test();
         end
      join_none
      cyc(6);
      {supply_above_18, supply_above_27, lv_monitor_ok, pll_enable, shutdown_cmd} = 5'h00;
      {wake_input_a_n, wake_input_b_n} = 2'h3;
      rst_b = 1'b1;
      cyc(2);
      // unselected comparator alone must not release reset
      if (monitor_threshold_select) supply_above_27 = 1'b1;
      else supply_above_18 = 1'b1;
      cyc(200);
      q.push_back(3'h5);
      {supply_above_18, supply_above_27} = 2'h3;
      drain(300);
      $display("done threshold and reset release");
      // short wake pulse ignored, long one powers up
      wake_input_b_n = 1'b0;
      cyc(2 + $unsigned($random(seed)) % 7);
      wake_input_b_n = 1'b1;
      cyc(60);
      chk({2'h0, standby_mode}, 3'h0);
      q.push_back(3'h7);
      wake_input_a_n = 1'b0;
      cyc(15);
      wake_input_a_n = 1'b1;
      drain(100);
      chk({2'h0, standby_mode}, 3'h1);
      $display("done wake");
      q.push_back(3'h6);
      q.push_back(3'h7);
      {lv_monitor_ok, pll_enable} = 2'h3;
      drain(800);
      $display("done clock start and interrupt");
      // shutdown with pll on: clock runs a while, stops, power stays up
      shutdown_cmd = 1'b1;
      cyc(3);
      shutdown_cmd = 1'b0;
      hf_act(30);
      chk({2'h0, act}, 3'h1);
      cyc(120);
      hf_act(40);
      chk({2'h0, act}, 3'h0);
      $display("done shutdown with pll on");
      // wake again restarts the clock, slow ack this time
      slow = 1'b1;
      q.push_back(3'h6);
      q.push_back(3'h7);
      wake_input_b_n = 1'b0;
      cyc(15);
      wake_input_b_n = 1'b1;
      drain(900);
      $display("done restart");
      pll_enable = 1'b0;
      cyc(40);
      q.push_back(3'h5);
      shutdown_cmd = 1'b1;
      cyc(3);
      shutdown_cmd = 1'b0;
      cyc(80);
      chk({2'h0, converter_power_off_n}, 3'h1);
      drain(200);
      chk({2'h0, standby_mode}, 3'h0);
      $display("done power off");
      q.push_back(3'h1);
      // other threshold now selected: losing only its comparator must pull reset
      monitor_threshold_select = ~monitor_threshold_select;
      if (monitor_threshold_select) supply_above_18 = 1'b0;
      else supply_above_27 = 1'b0;
      drain(20);
      $display("done supply drop");
      end_of_test();
   end
endmodule : tb_wscs_sequencer
`default_nettype wire
